/* File: inc/slwsp_pkg.sv */
// =====================================================================
// shared constants of the late-write sram port
package slwsp_pkg;
	localparam int LANES = 4; // byte lanes
	localparam int LANE_W = 9; // bits per lane
	localparam int ADDR_W = 16; // default address width
	localparam int SLEEP_DELAY = 2; // cycles from synchronised sleep to effect
	localparam int PIPE_LAT = 2; // pipelined read/write latency
	localparam int FLOW_LAT = 1; // flow-through latency
	localparam logic [1:0] BURST_RST = 2'h0; // burst step after reset
	// command classes seen at a sampling edge
	typedef enum logic [1:0] {
		SLWSP_DESEL,
		SLWSP_READ,
		SLWSP_WRITE,
		SLWSP_CONT
	} slwsp_cmd_type;
endpackage

/* File: inc/slwsp_if.sv */
`timescale 1ns/1ps
// =====================================================================
// pins between memory controller and sram port
interface slwsp_if #(
	parameter int ADDR_W = slwsp_pkg::ADDR_W
);
	logic [ADDR_W-1:0] addr; // address, low two bits preset burst counter
	logic clk_en_n; // clock enable, active low
	logic write_n; // write enable, active low
	logic burst_step_or_load; // high steps counter, low loads address
	logic select_one_n;
	logic select_two;
	logic select_three_n;
	logic [slwsp_pkg::LANES-1:0] lane_write_n; // lane write strobes
	logic out_enable_n; // asynchronous output enable
	logic sleep_request; // asynchronous sleep
	logic latency_select_n; // low flow-through, high pipelined
	logic burst_order_n; // low linear, high interleaved
	// data bus: each end drives its own copy with an enable
	logic [slwsp_pkg::LANES*slwsp_pkg::LANE_W-1:0] dq_ctl_o;
	logic dq_ctl_oe;
	logic [slwsp_pkg::LANES*slwsp_pkg::LANE_W-1:0] dq_mem_o;
	logic dq_mem_oe;
	logic [slwsp_pkg::LANES*slwsp_pkg::LANE_W-1:0] dq;
	// wire level resolved from the enables
	assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
	modport mem (
		input addr, clk_en_n, write_n, burst_step_or_load, select_one_n,
		input select_two, select_three_n, lane_write_n, out_enable_n,
		input sleep_request, latency_select_n, burst_order_n, dq,
		output dq_mem_o, dq_mem_oe
	);
	modport ctl (
		output addr, clk_en_n, write_n, burst_step_or_load, select_one_n,
		output select_two, select_three_n, lane_write_n, out_enable_n,
		output sleep_request, latency_select_n, burst_order_n,
		output dq_ctl_o, dq_ctl_oe,
		input dq
	);
endinterface

/* File: rtl/slwsp_mem.sv */
`timescale 1ns/1ps
// =====================================================================
// sram end: late-write synchronous memory with burst counter
// How it works
// - each low lane strobe writes its byte
// - deasserted clock enable suspends accesses; sleep and output enable syncs keep running
// - synchronous inputs sampled on rising edges only
// - controller loads new address with advance low
// - all three selects active to select
// - selects one, three low; two high
// - any lane combination written per strobes
// - all strobes high means no write
// - read starts on selected load with write high
// - pipelined read data out two cycles later
// - write registers address, selects, strobes at command
// - pipelined write data at third edge
// - flow-through read one cycle shorter
// - flow-through write data at second edge
// - latency select low means flow-through
// - burst order low means linear sequence
// - low address bits preset counter, advance steps
// - sleep request is asynchronous, active high
// - output enable high floats data drivers
// - burst covers four addresses then wraps
// - interleaved burst xors step with base
// - sleep enters and leaves four cycles later
module slwsp_mem #(
	parameter int ADDR_W = slwsp_pkg::ADDR_W,
	parameter int DEPTH_W = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_gate_en,
	// pins
	slwsp_if.mem pins,
	// user side status
	output logic asleep,
	output logic [1:0] burst_index
);
	localparam int DW = slwsp_pkg::LANES * slwsp_pkg::LANE_W;
	// one pipeline stage of an access
	typedef struct packed {
		logic vld; // access in flight
		logic wr; // write access
		logic [slwsp_pkg::LANES-1:0] lanes; // active-high lane enables
		logic [DEPTH_W-1:0] addr; // effective address
	} slwsp_stage_type;
	// all state of the end except the memory array
	typedef struct packed {
		logic [1:0] oe_sync; // output enable synchroniser
		logic [1:0] zz_sync; // sleep synchroniser
		logic zz_hist; // one delay stage after the synchroniser
		logic sleep; // in sleep
		logic [DEPTH_W-1:0] base; // loaded address
		logic [1:0] step; // burst step count
		logic active; // last load selected the device
		logic last_wr; // last loaded access was a write
		slwsp_stage_type s1; // command stage
		slwsp_stage_type s2; // second stage (pipelined only)
		logic [DW-1:0] q; // output register
		logic q_on; // drive enable for output register
	} slwsp_mem_state_type;
	slwsp_mem_state_type st_r, st_nxt;
	logic [DW-1:0] core [0:(1<<DEPTH_W)-1]; // memory array
	// =====================================================================
	// burst address from base and step
	function automatic logic [1:0] burst_low(input logic [1:0] b, input logic [1:0] s,
			input logic ilv);
		burst_low = ilv ? (b ^ s) : 2'(b + s);
	endfunction
	// =====================================================================
	// decode of the sampled command
	logic sel; // device selected
	logic [DEPTH_W-1:0] cur_addr; // effective address this cycle
	slwsp_pkg::slwsp_cmd_type cmd;
	logic flow; // flow-through mode
	slwsp_stage_type wstage; // stage whose data is on the bus now
	always_comb begin
		sel = !pins.select_one_n && pins.select_two && !pins.select_three_n;
		flow = !pins.latency_select_n;
		if (pins.burst_step_or_load)
			cmd = slwsp_pkg::SLWSP_CONT;
		else if (!sel)
			cmd = slwsp_pkg::SLWSP_DESEL;
		else if (pins.write_n)
			cmd = slwsp_pkg::SLWSP_READ;
		else
			cmd = slwsp_pkg::SLWSP_WRITE;
		wstage = flow ? st_r.s1 : st_r.s2;
		cur_addr = {st_r.base[DEPTH_W-1:2],
			burst_low(st_r.base[1:0], 2'(st_r.step + 2'h1), pins.burst_order_n)};
	end
	// =====================================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.oe_sync = {st_r.oe_sync[0], pins.out_enable_n};
		st_nxt.zz_sync = {st_r.zz_sync[0], pins.sleep_request};
		// sync output plus two stages: sleep follows the pin four edges late
		st_nxt.zz_hist = st_r.zz_sync[1];
		st_nxt.sleep = st_r.zz_hist;
		st_nxt.s2 = st_r.s1;
		st_nxt.s1 = '0;
		if (!pins.clk_en_n && !st_r.sleep) begin
			unique case (cmd)
				slwsp_pkg::SLWSP_READ, slwsp_pkg::SLWSP_WRITE: begin
					// load fresh address into counter
					st_nxt.base = pins.addr[DEPTH_W-1:0];
					st_nxt.step = slwsp_pkg::BURST_RST;
					st_nxt.active = 1'b1;
					st_nxt.last_wr = (cmd == slwsp_pkg::SLWSP_WRITE);
					st_nxt.s1.vld = 1'b1;
					st_nxt.s1.wr = st_nxt.last_wr;
					st_nxt.s1.lanes = ~pins.lane_write_n;
					st_nxt.s1.addr = pins.addr[DEPTH_W-1:0];
				end
				slwsp_pkg::SLWSP_CONT: begin
					// step counter; two bits wrap after four
					if (st_r.active) begin
						st_nxt.step = 2'(st_r.step + 2'h1);
						st_nxt.s1.vld = 1'b1;
						st_nxt.s1.wr = st_r.last_wr;
						st_nxt.s1.lanes = ~pins.lane_write_n;
						st_nxt.s1.addr = cur_addr;
					end
				end
				slwsp_pkg::SLWSP_DESEL: begin
					st_nxt.active = 1'b0;
				end
			endcase
			// output register loads read data of the command stage
			st_nxt.q_on = st_r.s1.vld && !st_r.s1.wr;
			st_nxt.q = core[st_r.s1.addr];
		end else if (!pins.clk_en_n) begin
			st_nxt.q_on = 1'b0;
		end
		if (pins.clk_en_n) begin
			// hold: pipeline and counter frozen
			st_nxt.s1 = st_r.s1;
			st_nxt.s2 = st_r.s2;
		end
	end
	// =====================================================================
	// state register
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			st_r <= '0;
		else if (clk_gate_en)
			st_r <= st_nxt;
	end
	// =====================================================================
	// late write into the array, per lane
	always_ff @(posedge clk_sys) begin
		if (clk_gate_en && !pins.clk_en_n && wstage.vld && wstage.wr) begin
			for (int i = 0; i < slwsp_pkg::LANES; i++) begin
				if (wstage.lanes[i])
					core[wstage.addr][i*slwsp_pkg::LANE_W +: slwsp_pkg::LANE_W] <=
						pins.dq[i*slwsp_pkg::LANE_W +: slwsp_pkg::LANE_W];
			end
		end
	end
	// =====================================================================
	// data drivers: flow-through bypasses the output register
	logic rd_flow; // flow-through read in command stage
	always_comb begin
		rd_flow = st_r.s1.vld && !st_r.s1.wr;
		pins.dq_mem_o = flow ? core[st_r.s1.addr] : st_r.q;
		pins.dq_mem_oe = !st_r.oe_sync[1] && !st_r.sleep && (flow ? rd_flow : st_r.q_on);
	end
	assign asleep = st_r.sleep;
	assign burst_index = st_r.step;
endmodule

/* File: rtl/slwsp_ctl.sv */
`timescale 1ns/1ps
// =====================================================================
// controller end: turns user requests into pin cycles
module slwsp_ctl #(
	parameter int ADDR_W = slwsp_pkg::ADDR_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_gate_en,
	// pins
	slwsp_if.ctl pins,
	// static configuration
	input wire logic cfg_flow,
	input wire logic cfg_interleave,
	input wire logic cfg_sleep,
	input wire logic cfg_out_off,
	// request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_burst,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [slwsp_pkg::LANES-1:0] req_lanes,
	input wire logic [slwsp_pkg::LANES*slwsp_pkg::LANE_W-1:0] req_data,
	// answer
	output logic rd_valid,
	output logic [slwsp_pkg::LANES*slwsp_pkg::LANE_W-1:0] rd_data
);
	localparam int DW = slwsp_pkg::LANES * slwsp_pkg::LANE_W;
	// delay line entry
	typedef struct packed {
		logic vld;
		logic wr;
		logic [DW-1:0] data;
	} slwsp_slot_type;
	typedef struct packed {
		slwsp_slot_type [1:0] line; // command delay line, one slot per latency cycle
		logic [DW-1:0] rd_data; // captured read data
		logic rd_valid;
	} slwsp_ctl_state_type;
	slwsp_ctl_state_type st_r, st_nxt;
	logic [1:0] lat; // latency in cycles
	// =====================================================================
	// pin drive and delay line
	always_comb begin
		lat = cfg_flow ? 2'(slwsp_pkg::FLOW_LAT) : 2'(slwsp_pkg::PIPE_LAT);
		st_nxt = st_r;
		st_nxt.line = {st_r.line[0], slwsp_slot_type'({req_valid, req_write, req_data})};
		// read data returns lat edges after command
		st_nxt.rd_valid = st_r.line[lat-2'h1].vld && !st_r.line[lat-2'h1].wr;
		st_nxt.rd_data = pins.dq;
		pins.addr = req_addr;
		pins.clk_en_n = !clk_gate_en;
		pins.write_n = !req_write;
		pins.burst_step_or_load = req_valid && req_burst;
		pins.select_one_n = !(req_valid && !req_burst);
		pins.select_two = 1'b1;
		pins.select_three_n = 1'b0;
		pins.lane_write_n = req_write ? ~req_lanes : '1;
		pins.out_enable_n = cfg_out_off;
		pins.sleep_request = cfg_sleep;
		pins.latency_select_n = !cfg_flow;
		pins.burst_order_n = cfg_interleave;
		// write data presented lat cycles late
		pins.dq_ctl_o = st_r.line[lat-2'h1].data;
		pins.dq_ctl_oe = st_r.line[lat-2'h1].vld && st_r.line[lat-2'h1].wr;
	end
	// =====================================================================
	// state register
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			st_r <= '0;
		else if (clk_gate_en)
			st_r <= st_nxt;
	end
	assign rd_valid = st_r.rd_valid;
	assign rd_data = st_r.rd_data;
endmodule

/* File: dv/slwsp_chk.sv */
`timescale 1ns/1ps
// =====================================================================
// pin checks between controller end and sram end
module slwsp_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// control pins
	input wire logic clk_en_n,
	input wire logic write_n,
	input wire logic burst_step_or_load,
	input wire logic select_one_n,
	input wire logic select_two,
	input wire logic select_three_n,
	input wire logic [slwsp_pkg::LANES-1:0] lane_write_n,
	input wire logic out_enable_n,
	input wire logic sleep_request,
	input wire logic latency_select_n,
	// data drivers
	input wire logic dq_ctl_oe,
	input wire logic dq_mem_oe,
	input wire logic [slwsp_pkg::LANES*slwsp_pkg::LANE_W-1:0] dq_mem_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [2:0] quiet_r; // cycles awake with outputs enabled
	logic sel, ld, rd_cmd, wr_cmd, desel;
	assign sel = !select_one_n && select_two && !select_three_n;
	assign ld = !clk_en_n && !burst_step_or_load;
	assign rd_cmd = ld && sel && write_n;
	assign wr_cmd = ld && sel && !write_n;
	assign desel = ld && !sel;
	// saturating count, covers the two-flop sync of async pins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) quiet_r <= 3'h0;
		else if (out_enable_n || sleep_request) quiet_r <= 3'h0;
		else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
	end
	chk_pipe_read: assert property (rd_cmd && latency_select_n && quiet_r == 3'h7
		##1 !clk_en_n |=> dq_mem_oe) else $error("pipelined read not driven");
	chk_flow_read: assert property (rd_cmd && !latency_select_n && quiet_r == 3'h7
		|=> dq_mem_oe) else $error("flow read not driven");
	chk_desel_quiet: assert property (desel [*3] |-> !dq_mem_oe)
		else $error("driven while deselected");
	chk_stall_hold: assert property (clk_en_n && quiet_r == 3'h7
		|=> $stable(dq_mem_oe) && $stable(dq_mem_o)) else $error("output moved in stall");
	chk_pipe_wdata: assert property (wr_cmd && latency_select_n && lane_write_n != 4'hf
		##1 !clk_en_n |=> dq_ctl_oe) else $error("late write data missing");
	chk_pipe_wnooe: assert property (wr_cmd && latency_select_n ##1 !clk_en_n
		|=> !dq_mem_oe) else $error("memory drove on write data edge");
	chk_flow_wdata: assert property (wr_cmd && !latency_select_n && lane_write_n != 4'hf
		|=> dq_ctl_oe && !dq_mem_oe) else $error("flow write data wrong");
	chk_oe_float: assert property (out_enable_n [*4] |-> !dq_mem_oe)
		else $error("driven with output enable high");
	cover property (rd_cmd && latency_select_n);
	cover property (rd_cmd && !latency_select_n);
	cover property (clk_en_n && quiet_r == 3'h7);
endmodule

/* File: dv/sync_late_write_sram_port_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
// =====================================================================
// both ends joined; user side of controller driven at falling edge
module sync_late_write_sram_port_test;
	localparam int DW = slwsp_pkg::LANES * slwsp_pkg::LANE_W;
	localparam logic [DW-1:0] D1 = 36'h123456789;
	localparam logic [DW-1:0] D2 = 36'hfedcba987;
	localparam logic [DW-1:0] M02 = 36'h007fc01ff; // lanes 0 and 2
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_gate_en = 1'b1;
	logic cfg_flow = 1'b0, cfg_interleave = 1'b0, cfg_sleep = 1'b0;
	logic cfg_out_off = 1'b0;
	logic req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0;
	logic [slwsp_pkg::ADDR_W-1:0] req_addr = '0;
	logic [3:0] req_lanes = '0;
	logic [DW-1:0] req_data = '0;
	logic rd_valid, asleep;
	logic [DW-1:0] rd_data;
	logic [1:0] burst_index;
	logic [DW-1:0] got_q[$]; // read answers in order
	int failures = 0;
	int cmp_count = 0;
	always #2.5 clk_sys = ~clk_sys;
	slwsp_if i_slwsp_if ();
	slwsp_ctl i_slwsp_ctl (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_gate_en(clk_gate_en),
		.pins(i_slwsp_if.ctl), .cfg_flow(cfg_flow), .cfg_interleave(cfg_interleave),
		.cfg_sleep(cfg_sleep), .cfg_out_off(cfg_out_off), .req_valid(req_valid),
		.req_write(req_write),
		.req_burst(req_burst), .req_addr(req_addr), .req_lanes(req_lanes),
		.req_data(req_data), .rd_valid(rd_valid), .rd_data(rd_data));
	slwsp_mem i_slwsp_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_gate_en(clk_gate_en),
		.pins(i_slwsp_if.mem), .asleep(asleep), .burst_index(burst_index));
	slwsp_chk i_slwsp_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.clk_en_n(i_slwsp_if.clk_en_n), .write_n(i_slwsp_if.write_n),
		.burst_step_or_load(i_slwsp_if.burst_step_or_load),
		.select_one_n(i_slwsp_if.select_one_n), .select_two(i_slwsp_if.select_two),
		.select_three_n(i_slwsp_if.select_three_n), .lane_write_n(i_slwsp_if.lane_write_n),
		.out_enable_n(i_slwsp_if.out_enable_n), .sleep_request(i_slwsp_if.sleep_request),
		.latency_select_n(i_slwsp_if.latency_select_n), .dq_ctl_oe(i_slwsp_if.dq_ctl_oe),
		.dq_mem_oe(i_slwsp_if.dq_mem_oe), .dq_mem_o(i_slwsp_if.dq_mem_o));
	// collect every answer pulse
	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1) got_q.push_back(rd_data);
	end
	// one request cycle
	task automatic send(input logic w, input logic b, input logic [15:0] a,
		input logic [3:0] l, input logic [DW-1:0] d);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_write = w;
		req_burst = b;
		req_addr = a;
		req_lanes = l;
		req_data = d;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys) req_valid = 1'b0;
	endtask
	// bounded wait for the next answer, then compare
	task automatic take(input logic [DW-1:0] e);
		int k;
		logic [DW-1:0] g;
		k = 0;
		while (got_q.size() == 0 && k < 20) begin
			@(negedge clk_sys);
			k++;
		end
		if (got_q.size() == 0) got_q.push_back('x);
		// pop once: the compare macro reads its argument twice
		g = got_q.pop_front();
		`CHK("rd_data", e, g)
	endtask
	// back-to-back writes with partial and empty lane sets
	task automatic t_lanes(input logic flow);
		cfg_flow = flow;
		idle(4);
		send(1'b1, 1'b0, 16'h0020, 4'hf, D1);
		send(1'b1, 1'b0, 16'h0020, 4'h5, D2);
		send(1'b1, 1'b0, 16'h0020, 4'h0, 36'h0);
		idle(4);
		send(1'b0, 1'b0, 16'h0020, 4'h0, 36'h0);
		idle(1);
		take((D2 & M02) | (D1 & ~M02));
		$display("lanes test done, flow %0d", flow);
	endtask
	// load at base 1, four continues (the last wraps), in either burst order
	task automatic t_burst(input logic ilv);
		cfg_interleave = ilv;
		idle(4);
		for (int i = 0; i < 4; i++) send(1'b1, 1'b0, 16'h0010 + 16'(i), 4'hf, 36'h111111111 * i);
		idle(4);
		send(1'b0, 1'b0, 16'h0011, 4'h0, 36'h0);
		for (int j = 1; j < 5; j++) send(1'b0, 1'b1, 16'h0000, 4'h0, 36'h0);
		`CHK("burst_index", 2'h3, burst_index)
		idle(1);
		`CHK("burst_index wrap", 2'h0, burst_index)
		for (int j = 0; j < 5; j++)
			take(36'h111111111 * (ilv ? 4'(1 ^ (j % 4)) : 4'((1 + j) % 4)));
		$display("burst test done, interleave %0d", ilv);
	endtask
	// read frozen by clock enable for three edges
	task automatic t_stall();
		send(1'b0, 1'b0, 16'h0012, 4'h0, 36'h0);
		@(negedge clk_sys);
		req_valid = 1'b0;
		clk_gate_en = 1'b0;
		repeat (3) @(negedge clk_sys);
		`CHK("no answer in stall", 0, got_q.size())
		clk_gate_en = 1'b1;
		take(36'h222222222);
		$display("stall test done");
	endtask
	// output enable held high floats the data drivers
	task automatic t_float();
		cfg_out_off = 1'b1;
		idle(4);
		send(1'b0, 1'b0, 16'h0013, 4'h0, 36'h0);
		idle(1);
		take(36'h0);
		cfg_out_off = 1'b0;
		idle(4);
		$display("float test done");
	endtask
	// sleep enters and leaves late, state kept
	task automatic t_sleep();
		cfg_sleep = 1'b1;
		idle(3);
		`CHK("asleep early", 1'b0, asleep)
		idle(1);
		`CHK("asleep", 1'b1, asleep)
		// a read while asleep is refused: nothing drives the bus
		send(1'b0, 1'b0, 16'h0013, 4'h0, 36'h0);
		idle(1);
		take(36'h0);
		cfg_sleep = 1'b0;
		idle(3);
		`CHK("awake early", 1'b1, asleep)
		idle(1);
		`CHK("awake", 1'b0, asleep)
		idle(4);
		send(1'b0, 1'b0, 16'h0013, 4'h0, 36'h0);
		idle(1);
		take(36'h333333333);
		$display("sleep test done");
	endtask
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_lanes(1'b0);
		t_lanes(1'b1);
		t_burst(1'b0);
		t_burst(1'b1);
		cfg_flow = 1'b0;
		idle(4);
		t_stall();
		t_float();
		t_sleep();
		conclude();
	end
	// watchdog well past the expected run
	initial begin
		#5000;
		failures++;
		conclude();
	end
endmodule
